/* logic/emr_one_pkg.sv */
// Package of constants for the first extended mode register block
package emr_one_pkg;
  // Command decode: chip select, row, column and write strobes, all active low
  localparam logic [1:0] BANK_SEL_EMR1 = 2'h1; // bank select 0 high, bank select 1 low
  localparam int ADDR_W = 14;
  // Field positions inside the register word
  localparam int DLL_OFF_BIT = 0;
  localparam int DRIVE_HALF_BIT = 1;
  localparam int ODT_LO_BIT = 2;
  localparam int LAT_LSB = 3;
  localparam int ODT_HI_BIT = 6;
  localparam int CAL_LSB = 7;
  localparam int STROBE_COMP_OFF_BIT = 10;
  localparam int READ_STROBE_BIT = 11;
  localparam int OUT_OFF_BIT = 12;
  // Reset value of the held word (the device itself defines none)
  localparam logic [13:0] WORD_RESET = 14'h0000;
  // Calibration program codes
  localparam logic [2:0] CAL_EXIT = 3'h0;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;
  // Largest legal additive latency code
  localparam logic [2:0] LAT_MAX = 3'h5;
  // Termination selections
  localparam logic [1:0] ODT_OFF = 2'h0;
  localparam logic [1:0] ODT_75 = 2'h1;
  localparam logic [1:0] ODT_150 = 2'h2;
  localparam logic [1:0] ODT_50 = 2'h3;
  // Lock wait after the delay loop is re-enabled, in clocks
  localparam int LOCK_CYCLES = 200;
endpackage

/* logic/emr_one_decode.sv */
// Field decoder for the held extended mode word
`timescale 1ns/100ps
module emr_one_decode
(
  input wire logic [13:0] word,
  output logic dll_on,
  output logic drive_reduced,
  output logic [1:0] odt_sel,
  output logic [2:0] lat_code,
  output logic lat_valid,
  output logic [2:0] cal_code,
  output logic cal_valid,
  output logic comp_strobe_off,
  output logic read_strobe_on,
  output logic out_off
);
  // Split the word into its functions
  always_comb
  begin
    dll_on = ~word[emr_one_pkg::DLL_OFF_BIT];
    drive_reduced = word[emr_one_pkg::DRIVE_HALF_BIT];
    odt_sel = {word[emr_one_pkg::ODT_HI_BIT], word[emr_one_pkg::ODT_LO_BIT]};
    lat_code = word[emr_one_pkg::LAT_LSB +: 3];
    lat_valid = (lat_code <= emr_one_pkg::LAT_MAX);
    cal_code = word[emr_one_pkg::CAL_LSB +: 3];
    cal_valid = (cal_code == emr_one_pkg::CAL_EXIT) || (cal_code == emr_one_pkg::CAL_DEFAULT);
    comp_strobe_off = word[emr_one_pkg::STROBE_COMP_OFF_BIT];
    read_strobe_on = word[emr_one_pkg::READ_STROBE_BIT];
    out_off = word[emr_one_pkg::OUT_OFF_BIT];
  end
endmodule

/* logic/emr_one_reg.sv */
// First extended mode register with its decoded controls
`timescale 1ns/100ps
// Operation
// - Load address bits on decoded command, bank 01
// - Rewrite allowed only while all precharged
// - Self refresh turns loop off, exit returns it to the A0 setting
// - A11 read strobe, A10 complement off
// - A9..A7 driver calibration program codes
// - A5..A3 additive latency, 0 to 5
module emr_one_reg
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [13:0] addr,
  input wire logic cke,
  input wire logic all_precharged,
  input wire logic self_refresh,
  output logic [13:0] extended_mode_word_one,
  output logic dll_active,
  output logic dll_locked,
  output logic drive_reduced,
  output logic [1:0] odt_sel,
  output logic [2:0] additive_latency,
  output logic [2:0] driver_calibration_program,
  output logic cal_default_load,
  output logic mask_pin_is_strobe,
  output logic comp_strobe_float,
  output logic read_comp_strobe_float,
  output logic out_buffers_off,
  output logic bad_code
);
  typedef struct packed {
    logic [13:0] word;
    logic dll_active;
    logic [7:0] lock_cnt;
    logic dll_locked;
    logic drive_reduced;
    logic [1:0] odt_sel;
    logic [2:0] lat;
    logic [2:0] cal;
    logic cal_load;
    logic mask_strobe;
    logic comp_float;
    logic rcomp_float;
    logic out_off;
    logic bad;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic wr_hit;
  logic dec_dll_on;
  logic dec_drive;
  logic [1:0] dec_odt;
  logic [2:0] dec_lat;
  logic dec_lat_ok;
  logic [2:0] dec_cal;
  logic dec_cal_ok;
  logic dec_comp_off;
  logic dec_rstrobe;
  logic dec_out_off;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the held word
  emr_one_decode u_dec
  (
    .word(s_q.word),
    .dll_on(dec_dll_on),
    .drive_reduced(dec_drive),
    .odt_sel(dec_odt),
    .lat_code(dec_lat),
    .lat_valid(dec_lat_ok),
    .cal_code(dec_cal),
    .cal_valid(dec_cal_ok),
    .comp_strobe_off(dec_comp_off),
    .read_strobe_on(dec_rstrobe),
    .out_off(dec_out_off)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode set command aimed at this register, only when idle and precharged
  assign wr_hit = !cs_n && !ras_n && !cas_n && !we_n && cke && all_precharged
                  && (ba == emr_one_pkg::BANK_SEL_EMR1);

  // Next state
  always_comb
  begin
    s_d = s_q;
    if (wr_hit)
    begin
      s_d.word = addr;
    end
    // Loop follows the word, but self refresh forces it off
    s_d.dll_active = dec_dll_on && !self_refresh;
    if (!s_q.dll_active)
    begin
      s_d.lock_cnt = 8'h00;
      s_d.dll_locked = 1'b0;
    end
    else if (s_q.lock_cnt != 8'(emr_one_pkg::LOCK_CYCLES - 1))
    begin
      s_d.lock_cnt = s_q.lock_cnt + 8'h01;
    end
    else
    begin
      s_d.dll_locked = 1'b1;
    end
    s_d.drive_reduced = dec_drive;
    s_d.odt_sel = dec_odt;
    s_d.lat = dec_lat_ok ? dec_lat : 3'h0;
    s_d.cal = dec_cal;
    s_d.cal_load = (dec_cal == emr_one_pkg::CAL_DEFAULT);
    s_d.mask_strobe = dec_rstrobe;
    s_d.comp_float = dec_comp_off;
    s_d.rcomp_float = dec_comp_off || !dec_rstrobe;
    s_d.out_off = dec_out_off;
    s_d.bad = !dec_lat_ok || !dec_cal_ok;
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '{word: emr_one_pkg::WORD_RESET, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state
  assign extended_mode_word_one = s_q.word;
  assign dll_active = s_q.dll_active;
  assign dll_locked = s_q.dll_locked;
  assign drive_reduced = s_q.drive_reduced;
  assign odt_sel = s_q.odt_sel;
  assign additive_latency = s_q.lat;
  assign driver_calibration_program = s_q.cal;
  assign cal_default_load = s_q.cal_load;
  assign mask_pin_is_strobe = s_q.mask_strobe;
  assign comp_strobe_float = s_q.comp_float;
  assign read_comp_strobe_float = s_q.rcomp_float;
  assign out_buffers_off = s_q.out_off;
  assign bad_code = s_q.bad;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Run length of the active loop, saturating, for the lock checks
  logic [7:0] run_q;

  // Counts consecutive cycles with the loop on
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_q <= 8'h00;
    end
    else if (!dll_active)
    begin
      run_q <= 8'h00;
    end
    else if (run_q != 8'hff)
    begin
      run_q <= run_q + 8'h01;
    end
  end

  // Load, refusal and loop properties
  word_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_hit |=> extended_mode_word_one == $past(addr)) else $error("word not loaded");
  busy_block_a: assert property (@(posedge clk) disable iff (!arst_n)
    !all_precharged |=> $stable(extended_mode_word_one)) else $error("write while banks open");
  cke_block_a: assert property (@(posedge clk) disable iff (!arst_n)
    !cke |=> $stable(extended_mode_word_one)) else $error("write while clock disabled");
  self_ref_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    self_refresh |=> !dll_active) else $error("loop on in self refresh");
  loop_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
    !self_refresh && !extended_mode_word_one[0] |=> dll_active) else $error("loop not on");
  lock_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(dll_active) |-> !dll_locked [*8]) else $error("locked too early");
  lock_done_a: assert property (@(posedge clk) disable iff (!arst_n)
    run_q >= 8'(emr_one_pkg::LOCK_CYCLES) |-> dll_locked) else $error("lock late");
  lock_early_a: assert property (@(posedge clk) disable iff (!arst_n)
    dll_locked |-> run_q >= 8'(emr_one_pkg::LOCK_CYCLES)) else $error("locked before wait");

  // Field decode properties
  odt_map_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 odt_sel == $past({extended_mode_word_one[6], extended_mode_word_one[2]}))
    else $error("termination wrong");
  drive_map_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 drive_reduced == $past(extended_mode_word_one[1])) else $error("drive strength wrong");
  lat_map_a: assert property (@(posedge clk) disable iff (!arst_n)
    $past(extended_mode_word_one[5:3]) <= 3'h5 |-> additive_latency == $past(extended_mode_word_one[5:3]))
    else $error("latency wrong");
  lat_bad_a: assert property (@(posedge clk) disable iff (!arst_n)
    $past(extended_mode_word_one[5:3]) > 3'h5 |-> bad_code && additive_latency == 3'h0)
    else $error("reserved latency not flagged");
  strobe_map_a: assert property (@(posedge clk) disable iff (!arst_n)
    $past(extended_mode_word_one[10]) |-> comp_strobe_float && read_comp_strobe_float)
    else $error("complement not floated");
  mask_map_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 mask_pin_is_strobe == $past(extended_mode_word_one[11])) else $error("mask pin mode wrong");
  out_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 out_buffers_off == $past(extended_mode_word_one[12])) else $error("output off wrong");
  cal_code_a: assert property (@(posedge clk) disable iff (!arst_n)
    $past(extended_mode_word_one[9:7]) == 3'h1 |-> bad_code) else $error("reserved not flagged");
  cal_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 cal_default_load == ($past(extended_mode_word_one[9:7]) == 3'h7)) else $error("default load wrong");

  // Main scenarios
  write_c: cover property (@(posedge clk) disable iff (!arst_n) wr_hit);
  refused_c: cover property (@(posedge clk) disable iff (!arst_n)
    !cs_n && !ras_n && !cas_n && !we_n && !all_precharged);
  lock_c: cover property (@(posedge clk) disable iff (!arst_n) $rose(dll_locked));
  selfref_c: cover property (@(posedge clk) disable iff (!arst_n) dll_locked ##1 self_refresh);
endmodule

/* sim/ctrl_model.sv */
// Controller model driving command and address pins of the register
`timescale 1ns/100ps
module ctrl_model
(
  input wire logic clk,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [13:0] addr,
  output logic cke,
  output logic all_precharged
);
  localparam int SET_GAP = 2; // Mode set cycle time in clocks
  // Idle bus, clock enable already high
  initial {cs_n, ras_n, cas_n, we_n, ba, addr, cke, all_precharged} = {4'hf, 2'h0, 14'h0, 2'h3};
  // One write command, then released pins and the cycle time
  task automatic put(input logic [13:0] w, input logic pre, input logic ck);
    @(posedge clk) #1;
    {cs_n, ras_n, cas_n, we_n, ba, addr, cke, all_precharged} = {4'h0, 2'h1, w, ck, pre};
    @(posedge clk) #1;
    {cs_n, ras_n, cas_n, we_n, ba, addr, cke, all_precharged} = {4'hf, ~ba, ~w, 2'h3};
    repeat (SET_GAP) @(posedge clk);
  endtask
endmodule

/* sim/test_emr_one_reg.sv */
// Self-checking bench for the first extended mode register
`timescale 1ns/100ps
module test_emr_one_reg;
  logic clk, arst_n, cs_n, ras_n, cas_n, we_n, cke, all_precharged, self_refresh;
  logic [1:0] ba, odt_sel;
  logic [13:0] addr, word, m, w;
  logic [2:0] lat, cal;
  logic dll_active, dll_locked, drive_reduced, cal_default_load, mask_pin_is_strobe;
  logic comp_strobe_float, read_comp_strobe_float, out_buffers_off, bad_code, pre, ck;
  int n_fail, check_count, cyc;
  ctrl_model ctrl_model_inst (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .cke(cke), .all_precharged(all_precharged));
  emr_one_reg emr_one_reg_inst (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .cke(cke), .all_precharged(all_precharged), .self_refresh(self_refresh),
    .extended_mode_word_one(word), .dll_active(dll_active), .dll_locked(dll_locked),
    .drive_reduced(drive_reduced), .odt_sel(odt_sel), .additive_latency(lat),
    .driver_calibration_program(cal), .cal_default_load(cal_default_load),
    .mask_pin_is_strobe(mask_pin_is_strobe), .comp_strobe_float(comp_strobe_float),
    .read_comp_strobe_float(read_comp_strobe_float), .out_buffers_off(out_buffers_off), .bad_code(bad_code));
  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Model outputs against the design after settling
  task automatic cmp_all();
    @(posedge clk) #1;
    check(word, m);
    check(dll_active, !m[0] && !self_refresh);
    check(drive_reduced, m[1]);
    check(odt_sel, {m[6], m[2]});
    check(lat, (m[5:3] > emr_one_pkg::LAT_MAX) ? 3'h0 : m[5:3]);
    check(cal, m[9:7]);
    check(cal_default_load, m[9:7] == emr_one_pkg::CAL_DEFAULT);
    check(bad_code, m[5:3] > 3'h5 || (m[9:7] != 3'h0 && m[9:7] != 3'h7));
    check(mask_pin_is_strobe, m[11]);
    check(comp_strobe_float, m[10]);
    check(read_comp_strobe_float, m[10] | !m[11]);
    check(out_buffers_off, m[12]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    clk = 0;
    arst_n = 0;
    self_refresh = 0;
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    m = 14'h0;
    void'($urandom(32'h8204));
    repeat (2) @(posedge clk);
    #1 arst_n = 1;
    for (int i = 0; i < 40; i++)
    begin
      w = 14'($urandom);
      w[9:7] = (i < 8) ? 3'(i) : emr_one_pkg::CAL_EXIT;
      if (i < 8)
        w[5:3] = 3'(i);
      w[11] = i >= 30 && i[0];
      pre = i < 8 || i % 5 != 4;
      ck = i < 8 || i % 7 != 6;
      ctrl_model_inst.put(w, pre, ck);
      if (pre && ck)
        m = w;
      cmp_all();
    end
    ctrl_model_inst.put(14'h0, 1'h1, 1'h1);
    m = 14'h0;
    cmp_all();
    repeat (205) @(posedge clk);
    #1;
    check(dll_locked, 1'h1);
    @(posedge clk) #1 self_refresh = 1;
    repeat (3) @(posedge clk);
    #1;
    check(dll_active, 1'h0);
    check(dll_locked, 1'h0);
    self_refresh = 0;
    repeat (3) @(posedge clk);
    #1;
    check(dll_active, 1'h1);
    check(dll_locked, 1'h0);
    repeat (emr_one_pkg::LOCK_CYCLES - 3) @(posedge clk);
    #1;
    check(dll_locked, 1'h0);
    @(posedge clk) #1;
    check(dll_locked, 1'h1);
    // Second reset in mid-run, then programming again
    @(posedge clk) #1 arst_n = 0;
    @(posedge clk) #1;
    check(word, emr_one_pkg::WORD_RESET);
    check(dll_locked, 1'h0);
    arst_n = 1;
    m = emr_one_pkg::WORD_RESET;
    cmp_all();
    w = 14'($urandom);
    w[11] = 1'b0;
    ctrl_model_inst.put(w, 1'h1, 1'h1);
    m = w;
    cmp_all();
    wrap_up();
  end
endmodule
